// >>> include/pwob_defs.svh
// pwob_defs.svh: constants for the posted write ordering bridge
// assumes inclusion by bare name from the include path
`ifndef PWOB_DEFS_SVH
`define PWOB_DEFS_SVH
`define PWOB_AW 32
`define PWOB_DW 32
`define PWOB_IRQW 12
`define PWOB_CPUW 8
`define PWOB_NPIN 4
`define PWOB_PIO_DEPTH 4
`define PWOB_PIO_PW 2
`define PWOB_DMA_DEPTH 8
`define PWOB_DMA_PW 3
`define PWOB_CNT_W 4
`endif

// >>> include/pwob_pkg.sv
// pwob_pkg.sv: types for the posted write ordering bridge
// assumes pwob_defs.svh is on the include path
`include "pwob_defs.svh"
package pwob_pkg;
   typedef struct packed
   {
      logic [`PWOB_AW-1:0] addr;
      logic [`PWOB_DW-1:0] data;
   } pwob_xfer_t;
   typedef struct packed
   {
      logic [`PWOB_IRQW-1:0] irq;
      logic [`PWOB_CPUW-1:0] cpu;
   } pwob_irq_msg_t;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_PIO_DRAIN = 4'b0010,
      ST_RD_FWD = 4'b0100,
      ST_DMA_DRAIN = 4'b1000
   } pwob_state_t;
endpackage

// >>> design/pwob_bridge.sv
// pwob_bridge.sv: posted pio write queue, dma write buffer, irq forwarding
// assumes single clock, all inputs synchronous, downstream holds rdy levels
`timescale 1ns/10ps
`include "pwob_defs.svh"
// Operation
// - pio writes are posted, acked before delivery
// - read waits until posted pio writes delivered
// - no cross-processor order without flush read
// - dma writes buffered, drained only on interrupt
// - pio read never flushes dma buffer
// - send irq number and cpu to hub
// - hub message carries irq and target cpu
// - irq number wider than eight bits
module pwob_bridge
   import pwob_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // pio requests from hub
   input wire logic i_pio_wr_vld,
   input wire pwob_xfer_t i_pio_wr,
   output logic o_pio_wr_rdy,
   input wire logic i_pio_rd_vld,
   input wire logic [`PWOB_AW-1:0] i_pio_rd_addr,
   output logic o_pio_rd_rdy,
   // pio toward device bus
   output logic o_dev_vld,
   output logic o_dev_we,
   output pwob_xfer_t o_dev,
   input wire logic i_dev_rdy,
   // dma writes from device
   input wire logic i_dma_vld,
   input wire pwob_xfer_t i_dma,
   output logic o_dma_rdy,
   // dma writes to memory
   output logic o_mem_vld,
   output pwob_xfer_t o_mem,
   input wire logic i_mem_rdy,
   // interrupt pins and routing table
   input wire logic [`PWOB_NPIN-1:0] i_int_pin,
   input wire pwob_irq_msg_t [`PWOB_NPIN-1:0] i_irq_route,
   // interrupt message to system hub
   output logic o_hub_vld,
   output pwob_irq_msg_t o_hub_msg,
   input wire logic i_hub_rdy
);
   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   pwob_xfer_t pio_mem_q [`PWOB_PIO_DEPTH];
   pwob_xfer_t dma_mem_q [`PWOB_DMA_DEPTH];
   logic [`PWOB_PIO_PW-1:0] pio_wp_q, pio_wp_d, pio_rp_q, pio_rp_d;
   logic [`PWOB_PIO_PW:0] pio_cnt_q, pio_cnt_d;
   logic [`PWOB_DMA_PW-1:0] dma_wp_q, dma_wp_d, dma_rp_q, dma_rp_d;
   logic [`PWOB_DMA_PW:0] dma_cnt_q, dma_cnt_d;
   logic [`PWOB_DMA_PW:0] drain_left_q, drain_left_d;
   pwob_state_t st_q, st_d;
   logic [`PWOB_NPIN-1:0] pin_q, pend_q, pend_d;
   logic [$clog2(`PWOB_NPIN)-1:0] sel_q, sel_d;
   logic [`PWOB_AW-1:0] rd_addr_q, rd_addr_d;
   logic dev_vld_d, dev_we_d, mem_vld_d, hub_vld_d;
   pwob_xfer_t dev_d, mem_d;
   pwob_irq_msg_t hub_d;
   logic pio_rdy_d, rd_rdy_d, dma_rdy_d;
   logic pio_push, pio_pop, dma_push, dma_pop;

   // lowest pending pin index
   function automatic logic [$clog2(`PWOB_NPIN)-1:0] first_set
      (input logic [`PWOB_NPIN-1:0] v);
      first_set = '0;
      for (int i = `PWOB_NPIN-1; i >= 0; i--)
      begin
         if (v[i])
            first_set = i[$clog2(`PWOB_NPIN)-1:0];
      end
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      pio_wp_d = pio_wp_q;
      pio_rp_d = pio_rp_q;
      pio_cnt_d = pio_cnt_q;
      dma_wp_d = dma_wp_q;
      dma_rp_d = dma_rp_q;
      dma_cnt_d = dma_cnt_q;
      drain_left_d = drain_left_q;
      sel_d = sel_q;
      rd_addr_d = rd_addr_q;
      dev_vld_d = o_dev_vld;
      dev_we_d = o_dev_we;
      dev_d = o_dev;
      mem_vld_d = o_mem_vld;
      mem_d = o_mem;
      hub_vld_d = o_hub_vld;
      hub_d = o_hub_msg;
      rd_rdy_d = 1'b0;
      // rising edge on a pin latches a pending interrupt
      pend_d = pend_q | (i_int_pin & ~pin_q);
      // posted write acked once queued, before delivery
      pio_push = i_pio_wr_vld & o_pio_wr_rdy;
      pio_pop = 1'b0;
      dma_push = i_dma_vld & o_dma_rdy;
      dma_pop = 1'b0;
      if (o_dev_vld && i_dev_rdy)
         dev_vld_d = 1'b0;
      if (o_mem_vld && i_mem_rdy)
         mem_vld_d = 1'b0;
      if (o_hub_vld && i_hub_rdy)
         hub_vld_d = 1'b0;
      case (st_q)
         ST_IDLE:
         begin
            // requester still holds vld while the done pulse stands
            if (i_pio_rd_vld && !o_dev_vld && !o_pio_rd_rdy)
            begin
               rd_addr_d = i_pio_rd_addr;
               st_d = ST_PIO_DRAIN;
            end
            else if (pend_q != '0 && !o_hub_vld)
            begin
               sel_d = first_set(pend_q);
               drain_left_d = dma_cnt_q;
               st_d = ST_DMA_DRAIN;
            end
            else if (pio_cnt_q != '0 && !dev_vld_d)
               pio_pop = 1'b1;
         end
         ST_PIO_DRAIN:
         begin
            if (pio_cnt_q != '0)
            begin
               if (!dev_vld_d)
                  pio_pop = 1'b1;
            end
            else if (!dev_vld_d)
            begin
               dev_vld_d = 1'b1;
               dev_we_d = 1'b0;
               dev_d.addr = rd_addr_q;
               dev_d.data = '0;
               st_d = ST_RD_FWD;
            end
         end
         ST_RD_FWD:
         begin
            if (o_dev_vld && i_dev_rdy)
            begin
               rd_rdy_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_DMA_DRAIN:
         begin
            if (drain_left_q != '0)
            begin
               if (!mem_vld_d)
               begin
                  dma_pop = 1'b1;
                  drain_left_d = drain_left_q - 1'b1;
               end
            end
            else if (!mem_vld_d)
            begin
               hub_vld_d = 1'b1;
               hub_d = i_irq_route[sel_q];
               pend_d[sel_q] = i_int_pin[sel_q] & ~pin_q[sel_q];
               st_d = ST_IDLE;
            end
         end
         default:
            st_d = ST_IDLE;
      endcase
      if (pio_pop)
      begin
         dev_vld_d = 1'b1;
         dev_we_d = 1'b1;
         dev_d = pio_mem_q[pio_rp_q];
         pio_rp_d = pio_rp_q + 1'b1;
      end
      if (dma_pop)
      begin
         mem_vld_d = 1'b1;
         mem_d = dma_mem_q[dma_rp_q];
         dma_rp_d = dma_rp_q + 1'b1;
      end
      if (pio_push)
         pio_wp_d = pio_wp_q + 1'b1;
      if (dma_push)
         dma_wp_d = dma_wp_q + 1'b1;
      pio_cnt_d = pio_cnt_q + {{`PWOB_PIO_PW{1'b0}}, pio_push}
         - {{`PWOB_PIO_PW{1'b0}}, pio_pop};
      dma_cnt_d = dma_cnt_q + {{`PWOB_DMA_PW{1'b0}}, dma_push}
         - {{`PWOB_DMA_PW{1'b0}}, dma_pop};
      pio_rdy_d = pio_cnt_d < (`PWOB_PIO_PW+1)'(`PWOB_PIO_DEPTH - 1);
      dma_rdy_d = dma_cnt_d < (`PWOB_DMA_PW+1)'(`PWOB_DMA_DEPTH - 1);
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (pio_push)
         pio_mem_q[pio_wp_q] <= i_pio_wr;
      if (dma_push)
         dma_mem_q[dma_wp_q] <= i_dma;
      if (i_rst)
      begin
         st_q <= ST_IDLE;
         pio_wp_q <= '0;
         pio_rp_q <= '0;
         pio_cnt_q <= '0;
         dma_wp_q <= '0;
         dma_rp_q <= '0;
         dma_cnt_q <= '0;
         drain_left_q <= '0;
         sel_q <= '0;
         rd_addr_q <= '0;
         pin_q <= '0;
         pend_q <= '0;
         o_pio_wr_rdy <= 1'b0;
         o_pio_rd_rdy <= 1'b0;
         o_dma_rdy <= 1'b0;
         o_dev_vld <= 1'b0;
         o_dev_we <= 1'b0;
         o_dev <= '0;
         o_mem_vld <= 1'b0;
         o_mem <= '0;
         o_hub_vld <= 1'b0;
         o_hub_msg <= '0;
      end
      else
      begin
         st_q <= st_d;
         pio_wp_q <= pio_wp_d;
         pio_rp_q <= pio_rp_d;
         pio_cnt_q <= pio_cnt_d;
         dma_wp_q <= dma_wp_d;
         dma_rp_q <= dma_rp_d;
         dma_cnt_q <= dma_cnt_d;
         drain_left_q <= drain_left_d;
         sel_q <= sel_d;
         rd_addr_q <= rd_addr_d;
         pin_q <= i_int_pin;
         pend_q <= pend_d;
         o_pio_wr_rdy <= pio_rdy_d;
         o_pio_rd_rdy <= rd_rdy_d;
         o_dma_rdy <= dma_rdy_d;
         o_dev_vld <= dev_vld_d;
         o_dev_we <= dev_we_d;
         o_dev <= dev_d;
         o_mem_vld <= mem_vld_d;
         o_mem <= mem_d;
         o_hub_vld <= hub_vld_d;
         o_hub_msg <= hub_d;
      end
   end
endmodule // pwob_bridge

// >>> testbench/pwob_bridge_sva.sv
// pwob_bridge_sva.sv: assertions on the bridge ports
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
`include "pwob_defs.svh"
module pwob_bridge_sva
   import pwob_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_dev_rdy,
   input wire logic i_mem_rdy,
   input wire logic i_hub_rdy,
   input wire logic [`PWOB_NPIN-1:0] i_int_pin,
   input wire pwob_irq_msg_t [`PWOB_NPIN-1:0] i_irq_route,
   input wire logic o_pio_rd_rdy,
   input wire logic o_dev_vld,
   input wire logic o_dev_we,
   input wire pwob_xfer_t o_dev,
   input wire logic o_mem_vld,
   input wire pwob_xfer_t o_mem,
   input wire logic o_hub_vld,
   input wire pwob_irq_msg_t o_hub_msg
);
   logic seen_q;
   logic seen_d;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ----------------------------------------
   // any interrupt pin raised since reset
   // ----------------------------------------
   assign seen_d = i_rst ? 1'b0 : (seen_q | (|i_int_pin));
   always_ff @(posedge i_clk) seen_q <= seen_d;
   property p_dev_hold; o_dev_vld && !i_dev_rdy |=>
      o_dev_vld && $stable({o_dev_we, o_dev}); endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("dev drop");
   property p_mem_hold; o_mem_vld && !i_mem_rdy |=>
      o_mem_vld && $stable(o_mem); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("mem drop");
   property p_hub_hold; o_hub_vld && !i_hub_rdy |=>
      o_hub_vld && $stable(o_hub_msg); endproperty
   a_hub_hold: assert property (p_hub_hold) else $error("hub drop");
   property p_rd_done; o_pio_rd_rdy |->
      $past(o_dev_vld && i_dev_rdy && !o_dev_we); endproperty
   a_rd_done: assert property (p_rd_done) else $error("rd early");
   property p_no_drain; !seen_q |-> !o_mem_vld; endproperty
   a_no_drain: assert property (p_no_drain) else $error("drain");
   property p_irq_last; o_hub_vld |-> !o_mem_vld; endproperty
   a_irq_last: assert property (p_irq_last) else $error("irq 1st");
   property p_rd_no_dma; o_dev_vld && !o_dev_we |-> !o_mem_vld; endproperty
   a_rd_no_dma: assert property (p_rd_no_dma) else $error("rd dma");
   property p_route; o_hub_vld |-> o_hub_msg == i_irq_route[0] ||
      o_hub_msg == i_irq_route[1] || o_hub_msg == i_irq_route[2] ||
      o_hub_msg == i_irq_route[3]; endproperty
   a_route: assert property (p_route) else $error("route");
   c_rd: cover property (o_pio_rd_rdy);
   c_hub: cover property (o_hub_vld && i_hub_rdy);
   c_mem: cover property (o_mem_vld && !i_mem_rdy);
endmodule // pwob_bridge_sva
bind pwob_bridge pwob_bridge_sva i_sva (.i_clk(i_clk), .i_rst(i_rst),
   .i_dev_rdy(i_dev_rdy), .i_mem_rdy(i_mem_rdy), .i_hub_rdy(i_hub_rdy),
   .i_int_pin(i_int_pin), .i_irq_route(i_irq_route),
   .o_pio_rd_rdy(o_pio_rd_rdy), .o_dev_vld(o_dev_vld),
   .o_dev_we(o_dev_we), .o_dev(o_dev), .o_mem_vld(o_mem_vld),
   .o_mem(o_mem), .o_hub_vld(o_hub_vld), .o_hub_msg(o_hub_msg));

// >>> testbench/pwob_far_model.sv
// pwob_far_model.sv: ready answers of device bus, memory and hub
// assumes the bench picks prompt or slow answers
`timescale 1ns/10ps
module pwob_far_model
(
   input wire logic i_clk,
   input wire logic i_slow,
   output logic o_rdy
);
   logic [1:0] cnt_q = 2'h0;
   always @(posedge i_clk) cnt_q <= cnt_q + 2'h1;
   // slow mode accepts one cycle in four
   assign o_rdy = !i_slow || (cnt_q == 2'h3);
endmodule // pwob_far_model

// >>> testbench/pwob_bridge_bench.sv
// pwob_bridge_bench.sv: self-checking bench for the bridge
// assumes the far model answers for device bus, memory and hub
`timescale 1ns/10ps
module pwob_bridge_bench;
   import pwob_pkg::*;
   logic clk = 0, rst = 1, wv = 0, rv = 0, dmv = 0, slow = 0;
   logic wrdy, rrdy, dvld, dwe, dmrdy, mvld, hvld, rdy;
   logic [31:0] ra = 0;
   logic [3:0] pin = 0;
   logic [3:0] ack;
   pwob_xfer_t wx = 0, dmx = 0, dx, mx;
   pwob_irq_msg_t [3:0] route = {20'h1_3C03, 20'h1_2C02, 20'h1_1C01,
      20'h1_0C00};
   pwob_irq_msg_t hm;
   logic [64:0] dq[$];
   pwob_xfer_t mq[$];
   pwob_irq_msg_t hq[$];
   pwob_xfer_t rows[3] = '{64'h0000_0010_1234_5678,
      64'h0000_0020_FFFF_0000, 64'hFFFF_FFFC_0000_0001};
   int err_total = 0, tests_run = 0, n;
   pwob_bridge i_dut (.i_clk(clk), .i_rst(rst), .i_pio_wr_vld(wv),
      .i_pio_wr(wx), .o_pio_wr_rdy(wrdy), .i_pio_rd_vld(rv),
      .i_pio_rd_addr(ra), .o_pio_rd_rdy(rrdy), .o_dev_vld(dvld),
      .o_dev_we(dwe), .o_dev(dx), .i_dev_rdy(rdy), .i_dma_vld(dmv),
      .i_dma(dmx), .o_dma_rdy(dmrdy), .o_mem_vld(mvld), .o_mem(mx),
      .i_mem_rdy(rdy), .i_int_pin(pin), .i_irq_route(route),
      .o_hub_vld(hvld), .o_hub_msg(hm), .i_hub_rdy(rdy));
   pwob_far_model i_far (.i_clk(clk), .i_slow(slow), .o_rdy(rdy));
   assign ack = {hvld, dmrdy, rrdy, wrdy};
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      if (dvld && rdy) dq.push_back({dwe, dx});
      if (mvld && rdy) mq.push_back(mx);
      if (hvld && rdy) hq.push_back(hm);
   end
   task chk(input logic [64:0] s, input logic [64:0] e);
      tests_run++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // waits for handshake s, then steps just past the edge
   task hs(input int s);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack[s] !== 1'b1 && n < 300);
      #1;
      if (n >= 300) chk(0, 1);
   endtask
   task end_sim;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_total++;
      end_sim;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      #1 rst = 0;
      chk({dvld, mvld, hvld, rrdy, wrdy, dmrdy}, 0);
      @(posedge clk);
      #1;
      chk({wrdy, dmrdy}, 2'h3);
      foreach (rows[i])
      begin
         slow = i[0];
         wv = 1;
         wx = rows[i];
         hs(0);
         wx = ~rows[i];
         hs(0);
         wv = 0;
         rv = 1;
         ra = rows[i].addr;
         hs(1);
         rv = 0;
         chk(dq.pop_front(), {1'b1, rows[i]});
         chk(dq.pop_front(), {1'b1, ~rows[i]});
         chk(dq.pop_front(), {1'b0, rows[i].addr, 32'h0});
      end
      slow = 1;
      dmv = 1;
      foreach (rows[k])
      begin
         dmx = rows[k];
         hs(2);
      end
      dmv = 0;
      rv = 1;
      hs(1);
      rv = 0;
      repeat (20) @(posedge clk);
      #1;
      chk(mq.size(), 0);
      pin = 4'h4;
      hs(3);
      chk(mq.size(), 3);
      repeat (4) @(posedge clk);
      #1;
      foreach (rows[k]) chk(mq.pop_front(), rows[k]);
      chk(hq.pop_front(), route[2]);
      end_sim;
   end
endmodule // pwob_bridge_bench
